// ### dv/testbench.sv
// self-checking bench for the serial data path
`include "usd_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, psel, penable, pwrite, rx_in, xck_in;
	logic complete_irq_ack, pready, pslverr, tx_out, tx_oe, rx_sel;
	logic xck_sel, empty_irq, complete_irq, go, got_v, e;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [7:0] rb, fm;
	logic [3:0] nb;
	logic [11:0] got;
	logic [8:0] d;
	logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	int n_mismatch, comparisons, seed, i, sz;

	usd_datapath u_usd_datapath (.*);
	usd_partner u_usd_partner (.clk(clk), .tx_line(tx_out), .nbits(nb),
		.go(go), .byte_in(rb), .rx_line(rx_in), .got(got), .got_v(got_v));

	// free-running clock
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	// one apb transfer, waits for ready
	task automatic apb(input logic w, input logic [31:0] a, dt);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb

	task automatic chk(input logic [32:0] g, x);
		comparisons++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask : chk

	// expected line bits after the start: data, parity, stop
	function automatic logic [11:0] frame(input logic [8:0] v, input int n,
		input logic pen, odd);
		logic [11:0] f;
		logic p;
		f = 0;
		p = odd;
		for (int k = 0; k < n; k++) begin
			f[k] = v[k];
			p ^= v[k];
		end
		if (pen) f[n] = p;
		f[n + pen] = 1'b1;
		return f;
	endfunction : frame

	task automatic end_sim;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// watchdog against hangs
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end

	// main sequence
	initial begin
		seed = 32'h78b6f1b1;
		{reset_n, psel, penable, pwrite, go, complete_irq_ack} = 0;
		{paddr, pwdata, rb, nb} = 0;
		xck_in = 1;
		repeat (8) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		apb(0, `USD_OFF_STATUS, 0);
		chk(q, 32'h20);
		apb(0, `USD_OFF_FORMAT, 0);
		chk(q, 32'h03);
		apb(0, 32'h20, 0);
		chk({e, q}, 33'h1_0000_0000);
		for (i = 0; i < 10; i++) begin
			d = $random(seed);
			fm = ($random(seed) & 8'h38) | cd[i % 5];
			sz = (cd[i % 5] == 3'h7) ? 9 : cd[i % 5] + 5;
			// unused upper bits high: no false start, masking is visible
			rb = $random(seed) | (8'hff << sz);
			nb = sz + fm[4];
			apb(1, `USD_OFF_FORMAT, fm);
			apb(1, `USD_OFF_CONTROL, 8'h3c | d[8]);
			@(posedge clk);
			chk(rx_sel, 1);
			chk(empty_irq, 1);
			// let the partner finish the previous eleven-bit frame
			repeat (180) @(posedge clk);
			go <= 1;
			apb(1, `USD_OFF_DATA, d);
			go <= 0;
			@(got_v);
			chk(got, frame(d, sz, fm[4], fm[3]));
			do apb(0, `USD_OFF_STATUS, 0); while (q[7:6] !== 2'b11);
			chk(complete_irq, 1);
			chk(q & 32'he0, 32'he0);
			apb(0, `USD_OFF_DATA, 0);
			chk(q, rb & ~(8'hff << sz));
			if (i % 2) apb(1, `USD_OFF_STATUS, 32'h40);
			else begin
				complete_irq_ack <= 1;
				@(posedge clk);
				complete_irq_ack <= 0;
			end
			apb(0, `USD_OFF_STATUS, 0);
			chk(q & 32'he0, 32'h20);
		end
		// two queued frames, then transmitter off mid-frame
		apb(1, `USD_OFF_FORMAT, 8'h03);
		nb = 8;
		apb(1, `USD_OFF_DATA, 8'h5a);
		apb(1, `USD_OFF_DATA, 8'ha5);
		apb(0, `USD_OFF_STATUS, 0);
		chk(q[5], 0);
		apb(1, `USD_OFF_CONTROL, 8'h20);
		@(got_v);
		chk(got, frame(9'h5a, 8, 0, 0));
		chk(tx_oe, 1);
		@(got_v);
		chk(got, frame(9'ha5, 8, 0, 0));
		do apb(0, `USD_OFF_STATUS, 0); while (q[6] !== 1'b1);
		chk(tx_oe, 0);
		end_sim;
	end
endmodule : testbench

bind usd_datapath usd_sva u_usd_sva (.*);

// ### dv/usd_partner.sv
// remote transceiver: decodes the transmit line, sends frames
module usd_partner #(
	parameter int BT = 16
) (
	input wire logic clk,
	input wire logic tx_line,
	input wire logic [3:0] nbits,
	input wire logic go,
	input wire logic [7:0] byte_in,
	output logic rx_line,
	output logic [11:0] got,
	output logic got_v
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] sh;
	// sample mid-bit after each start edge; got_v toggles per frame
	initial begin
		got_v = 0;
		forever begin
			@(negedge tx_line);
			got = 0;
			repeat (BT / 2) @(posedge clk);
			for (int i = 0; i <= nbits; i++) begin
				repeat (BT) @(posedge clk);
				got[i] = tx_line;
			end
			got_v = ~got_v;
		end
	end
	// send start, eight bits lsb first, two stops; idle high
	initial begin
		rx_line = 1;
		forever begin
			@(posedge go);
			sh = {2'b11, byte_in, 1'b0};
			for (int i = 0; i < 11; i++) begin
				@(posedge clk);
				rx_line <= sh[i];
				repeat (BT - 1) @(posedge clk);
			end
		end
	end
endmodule : usd_partner

// ### dv/usd_sva.sv
// port assertions for the serial data path
module usd_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_out,
	input wire logic tx_oe,
	input wire logic rx_in,
	input wire logic rx_sel,
	input wire logic xck_in,
	input wire logic xck_sel,
	input wire logic empty_irq,
	input wire logic complete_irq,
	input wire logic complete_irq_ack
);
	// all checks run on the system clock
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	idle_high_a: assert property (!tx_oe |-> tx_out)
		else $error("line low while released");
	low_owned_a: assert property (!tx_out |-> tx_oe)
		else $error("line low without ownership");
	low_len_a: assert property ($fell(tx_out) |-> !tx_out [*8])
		else $error("low bit too short");
	high_len_a: assert property ($rose(tx_out) |-> tx_out [*8])
		else $error("high bit too short");
	wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("bus answer not after one wait");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	slverr_map_a: assert property (pslverr |-> pready && paddr[31:5] != 0)
		else $error("error on mapped address");
	ack_clear_a: assert property (complete_irq_ack |=> ##1 !complete_irq)
		else $error("complete request not cleared");
endmodule : usd_sva

// ### logic/usd_datapath.sv
// serial channel transmit and receive data path with an apb register slave
`include "usd_map.svh"

// Behaviour
// - transmit enable takes over the transmit pin
// - synchronous mode clocks frames from serial clock
// - data register write fills transmit buffer
// - buffer moves to shifter when idle or after stop
// - shifter sends one frame at selected rate
// - surplus upper bits ignored for short characters
// - nine-bit mode sends ninth transmit bit
// - empty flag mirrors transmit buffer emptiness
// - empty interrupt requested while flag set
// - data register write clears empty flag
// - complete flag set when frame out, buffer empty
// - complete flag cleared by acknowledge or write one
// - complete interrupt requested while flag set
// - parity inserted after data when enabled
// - transmit disable deferred until shifter, buffer empty
// - receive enable takes over the receive pin
// - receiver starts on valid start, samples bits
// - second stop bit ignored by receiver
// - first stop moves frame into receive buffer
// - unused upper received bits read as zero
// - frame is start, data lsb first, parity, stops
// - parity is xor of data, inverted if odd
// - receive complete flag shows unread data
module usd_datapath
	import usd_pkg::*;
#(
	parameter int NORMAL_OS = `USD_OS_NORMAL,
	parameter int DOUBLE_OS = `USD_OS_DOUBLE
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_out,
	output logic tx_oe,
	input wire logic rx_in,
	output logic rx_sel,
	input wire logic xck_in,
	output logic xck_sel,
	output logic empty_irq,
	output logic complete_irq,
	input wire logic complete_irq_ack
);
	// refuse oversampling factors that the four-bit counters cannot hold
	if (NORMAL_OS > 16 || DOUBLE_OS < 2 || DOUBLE_OS > NORMAL_OS
		|| NORMAL_OS % 2 != 0 || DOUBLE_OS % 2 != 0) begin : g_bad_os
		$error("usd_datapath: oversampling factors out of range");
	end

	usd_state_t s_reg;
	usd_state_t s_next;

	// combinational helpers
	logic access;
	logic wr_data;
	logic rd_data;
	logic [3:0] nbits;
	logic [3:0] os_last;
	logic [3:0] os_half;
	logic pre_tick;
	logic ck_change;
	logic ck_sample;
	logic tx_tick;
	logic rx_tick;
	logic tx_on;
	logic load_ok;
	logic frame_end;
	logic [8:0] tx_mask;
	logic [8:0] tx_word;
	logic [8:0] rx_word;
	logic txc_set;
	logic rxc_set;
	logic [4:0] addr;

	// next state of every register
	always_comb begin
		s_next = s_reg;
		addr = paddr[`USD_ADDR_W-1:0];
		access = psel && penable && s_reg.pready;
		wr_data = access && pwrite && addr == `USD_OFF_DATA
			&& paddr[31:`USD_ADDR_W] == '0;
		rd_data = access && !pwrite && addr == `USD_OFF_DATA
			&& paddr[31:`USD_ADDR_W] == '0;

		// character width from the size field, value 7 means nine bits
		if (s_reg.fmt[2:0] == `USD_SIZE_NINE) begin
			nbits = 4'h9;
		end else if (s_reg.fmt[2]) begin
			nbits = 4'h8;
		end else begin
			nbits = 4'(s_reg.fmt[1:0]) + 4'h5;
		end
		tx_mask = 9'((10'h001 << nbits) - 10'h001);

		// oversampling ticks from the baud divider
		pre_tick = s_reg.pre_cnt == '0;
		os_last = s_reg.ctrl[`USD_CT_DBL] ? 4'(DOUBLE_OS - 1)
			: 4'(NORMAL_OS - 1);
		os_half = s_reg.ctrl[`USD_CT_DBL] ? 4'(DOUBLE_OS / 2 - 1)
			: 4'(NORMAL_OS / 2 - 1);
		s_next.pre_cnt = pre_tick ? s_reg.baud : s_reg.pre_cnt - 12'h001;

		// external clock edges seen after the synchroniser
		s_next.xck_s1 = xck_in;
		s_next.xck_s2 = s_reg.xck_s1;
		s_next.xck_s3 = s_reg.xck_s2;
		if (s_reg.fmt[`USD_FM_POL]) begin
			ck_change = !s_reg.xck_s2 && s_reg.xck_s3;
			ck_sample = s_reg.xck_s2 && !s_reg.xck_s3;
		end else begin
			ck_change = s_reg.xck_s2 && !s_reg.xck_s3;
			ck_sample = !s_reg.xck_s2 && s_reg.xck_s3;
		end

		// transmit bit clock, internal divider or serial clock pin
		if (pre_tick) begin
			s_next.tx_os = s_reg.tx_os == os_last ? 4'h0
				: s_reg.tx_os + 4'h1;
		end
		tx_tick = s_reg.fmt[`USD_FM_SYNC] ? ck_change
			: pre_tick && s_reg.tx_os == os_last;

		// transmitter stays on until shifter and buffer are empty
		tx_on = s_reg.ctrl[`USD_CT_TXEN] || s_reg.tx_full
			|| s_reg.tx_st != USD_TX_IDLE;
		load_ok = s_reg.tx_full && tx_on;
		frame_end = 1'b0;
		txc_set = 1'b0;
		tx_word = s_reg.tx_buf & tx_mask;

		// transmit frame sequencer
		unique case (s_reg.tx_st)
			USD_TX_IDLE: begin
				s_next.tx_out = 1'b1;
				frame_end = load_ok;
			end
			USD_TX_START: begin
				if (tx_tick) begin
					s_next.tx_out = s_reg.tx_sh[0];
					s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
					s_next.tx_bits = 4'h1;
					s_next.tx_st = USD_TX_DATA;
				end
			end
			USD_TX_DATA: begin
				if (tx_tick) begin
					if (s_reg.tx_bits != nbits) begin
						s_next.tx_out = s_reg.tx_sh[0];
						s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
						s_next.tx_bits = s_reg.tx_bits + 4'h1;
					end else if (s_reg.fmt[`USD_FM_PEN]) begin
						s_next.tx_out = s_reg.tx_par;
						s_next.tx_st = USD_TX_PAR;
					end else begin
						s_next.tx_out = 1'b1;
						s_next.tx_st = USD_TX_STOP1;
					end
				end
			end
			USD_TX_PAR: begin
				if (tx_tick) begin
					s_next.tx_out = 1'b1;
					s_next.tx_st = USD_TX_STOP1;
				end
			end
			USD_TX_STOP1: begin
				if (tx_tick && s_reg.fmt[`USD_FM_STOP2]) begin
					s_next.tx_st = USD_TX_STOP2;
				end else if (tx_tick) begin
					frame_end = 1'b1;
				end
			end
			USD_TX_STOP2: begin
				frame_end = tx_tick;
			end
		endcase

		// load the shifter at idle or right after the last stop bit
		if (frame_end) begin
			if (load_ok) begin
				s_next.tx_sh = tx_word;
				s_next.tx_par = ^tx_word ^ s_reg.fmt[`USD_FM_ODD];
				s_next.tx_full = 1'b0;
				s_next.tx_out = 1'b0;
				s_next.tx_st = USD_TX_START;
				if (!s_reg.fmt[`USD_FM_SYNC]) begin
					s_next.tx_os = 4'h0;
				end
			end else begin
				s_next.tx_out = 1'b1;
				s_next.tx_st = USD_TX_IDLE;
				txc_set = s_reg.tx_st != USD_TX_IDLE;
			end
		end

		// a data write fills the buffer with the ninth bit beside it
		if (wr_data) begin
			s_next.tx_buf = {s_reg.ctrl[`USD_CT_TX9], pwdata[7:0]};
			s_next.tx_full = 1'b1;
		end

		// receiver sampling clock
		if (s_reg.fmt[`USD_FM_SYNC]) begin
			rx_tick = ck_sample;
		end else begin
			rx_tick = pre_tick;
		end
		rxc_set = 1'b0;
		rx_word = 9'(s_reg.rx_sh >> (4'h9 - nbits));

		// receive frame sequencer
		unique case (s_reg.rx_st)
			USD_RX_IDLE: begin
				if (rx_tick && !rx_in) begin
					s_next.rx_os = 4'h0;
					s_next.rx_bits = 4'h0;
					s_next.rx_st = s_reg.fmt[`USD_FM_SYNC] ? USD_RX_DATA
						: USD_RX_START;
				end
			end
			USD_RX_START: begin
				if (rx_tick) begin
					s_next.rx_os = s_reg.rx_os + 4'h1;
					if (s_reg.rx_os == os_half) begin
						s_next.rx_os = 4'h0;
						s_next.rx_st = rx_in ? USD_RX_IDLE
							: USD_RX_DATA;
					end
				end
			end
			default: begin
				if (rx_tick && !s_reg.fmt[`USD_FM_SYNC]) begin
					s_next.rx_os = s_reg.rx_os == os_last ? 4'h0
						: s_reg.rx_os + 4'h1;
				end
				if (rx_tick && (s_reg.fmt[`USD_FM_SYNC]
					|| s_reg.rx_os == os_last)) begin
					unique case (s_reg.rx_st)
						USD_RX_DATA: begin
							s_next.rx_sh = {rx_in, s_reg.rx_sh[8:1]};
							s_next.rx_bits = s_reg.rx_bits + 4'h1;
							if (s_reg.rx_bits == nbits - 4'h1) begin
								s_next.rx_st = s_reg.fmt[`USD_FM_PEN]
									? USD_RX_PAR : USD_RX_STOP;
							end
						end
						USD_RX_PAR: begin
							s_next.rx_st = USD_RX_STOP;
						end
						default: begin
							// second stop bit is left to the idle watcher
							s_next.rx_buf = rx_word;
							rxc_set = 1'b1;
							s_next.rx_st = USD_RX_IDLE;
						end
					endcase
				end
			end
		endcase

		// receive complete: reading the data clears, a new frame wins
		if (rd_data) begin
			s_next.rxc = 1'b0;
		end
		if (rxc_set) begin
			s_next.rxc = 1'b1;
		end

		// apb access phase: one wait state, then the answer
		s_next.pready = psel && penable && !s_reg.pready;
		s_next.pslverr = 1'b0;
		s_next.prdata = '0;
		if (psel && penable && !s_reg.pready) begin
			if (paddr[31:`USD_ADDR_W] != '0) begin
				s_next.pslverr = 1'b1;
			end else begin
				unique case (addr)
					`USD_OFF_DATA: s_next.prdata = {24'h0, s_reg.rx_buf[7:0]};
					`USD_OFF_STATUS: begin
						s_next.prdata[`USD_ST_RXC] = s_reg.rxc;
						s_next.prdata[`USD_ST_TXC] = s_reg.txc;
						s_next.prdata[`USD_ST_UDRE] = !s_reg.tx_full;
						s_next.prdata[`USD_ST_RX9] = s_reg.rx_buf[8];
					end
					`USD_OFF_CONTROL: s_next.prdata = {24'h0, s_reg.ctrl};
					`USD_OFF_FORMAT: s_next.prdata = {24'h0, s_reg.fmt};
					`USD_OFF_BAUD: s_next.prdata = {20'h0, s_reg.baud};
					default: s_next.pslverr = 1'b1;
				endcase
			end
		end

		// register writes take effect at the completing edge
		if (access && pwrite && paddr[31:`USD_ADDR_W] == '0) begin
			unique case (addr)
				`USD_OFF_STATUS: begin
					// empty flag position is read-only, software writes zero
					if (pwdata[`USD_ST_TXC]) begin
						s_next.txc = 1'b0;
					end
				end
				`USD_OFF_CONTROL: s_next.ctrl = pwdata[7:0];
				`USD_OFF_FORMAT: s_next.fmt = pwdata[7:0];
				`USD_OFF_BAUD: s_next.baud = pwdata[11:0];
				default: begin
				end
			endcase
		end

		// acknowledge of the complete interrupt clears the flag
		if (complete_irq_ack) begin
			s_next.txc = 1'b0;
		end
		if (txc_set) begin
			s_next.txc = 1'b1;
		end

		// receiver off: flush buffer and abort any reception
		if (!s_next.ctrl[`USD_CT_RXEN]) begin
			s_next.rxc = 1'b0;
			s_next.rx_st = USD_RX_IDLE;
		end

		// interrupt requests and pin takeover
		s_next.empty_irq = s_reg.ctrl[`USD_CT_EIE] && !s_reg.tx_full;
		s_next.complete_irq = s_reg.ctrl[`USD_CT_CIE] && s_reg.txc;
		s_next.tx_oe = tx_on;
		s_next.rx_sel = s_reg.ctrl[`USD_CT_RXEN];
		s_next.xck_sel = s_reg.fmt[`USD_FM_SYNC]
			&& (tx_on || s_reg.ctrl[`USD_CT_RXEN]);
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
			s_reg.fmt <= {5'h00, `USD_SIZE_RST};
			s_reg.tx_out <= 1'b1;
			s_reg.tx_st <= USD_TX_IDLE;
			s_reg.rx_st <= USD_RX_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state register
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign tx_out = s_reg.tx_out;
	assign tx_oe = s_reg.tx_oe;
	assign rx_sel = s_reg.rx_sel;
	assign xck_sel = s_reg.xck_sel;
	assign empty_irq = s_reg.empty_irq;
	assign complete_irq = s_reg.complete_irq;
endmodule : usd_datapath

// ### logic/usd_map.svh
// register offsets, field positions, reset values and timing constants
`ifndef USD_MAP_SVH
`define USD_MAP_SVH
`define USD_ADDR_W 5
`define USD_OFF_DATA 5'h00
`define USD_OFF_STATUS 5'h04
`define USD_OFF_CONTROL 5'h08
`define USD_OFF_FORMAT 5'h0c
`define USD_OFF_BAUD 5'h10
// status register bits
`define USD_ST_RXC 7
`define USD_ST_TXC 6
`define USD_ST_UDRE 5
`define USD_ST_RX9 0
// control register bits
`define USD_CT_TX9 0
`define USD_CT_DBL 1
`define USD_CT_EIE 2
`define USD_CT_CIE 3
`define USD_CT_TXEN 4
`define USD_CT_RXEN 5
// format register bits
`define USD_FM_SIZE_LSB 0
`define USD_FM_ODD 3
`define USD_FM_PEN 4
`define USD_FM_STOP2 5
`define USD_FM_SYNC 6
`define USD_FM_POL 7
`define USD_SIZE_RST 3'h3
`define USD_SIZE_NINE 3'h7
`define USD_BAUD_W 12
`define USD_OS_NORMAL 16
`define USD_OS_DOUBLE 8
`endif

// ### logic/usd_pkg.sv
// types of the serial transmit and receive data path
package usd_pkg;
	typedef enum logic [2:0] {
		USD_TX_IDLE, USD_TX_START, USD_TX_DATA, USD_TX_PAR,
		USD_TX_STOP1, USD_TX_STOP2
	} usd_tx_state_t;
	typedef enum logic [2:0] {
		USD_RX_IDLE, USD_RX_START, USD_RX_DATA, USD_RX_PAR, USD_RX_STOP
	} usd_rx_state_t;
	typedef struct packed {
		logic pready; logic pslverr; logic [31:0] prdata;
		logic [7:0] ctrl; logic [7:0] fmt; logic [11:0] baud;
		logic [11:0] pre_cnt; logic [3:0] tx_os; logic [3:0] rx_os;
		logic xck_s1; logic xck_s2; logic xck_s3;
		usd_tx_state_t tx_st; logic [8:0] tx_buf; logic tx_full;
		logic [8:0] tx_sh; logic tx_par; logic [3:0] tx_bits;
		logic tx_out; logic tx_oe; logic txc; logic empty_irq;
		logic complete_irq; logic rx_sel; logic xck_sel;
		usd_rx_state_t rx_st; logic [8:0] rx_sh; logic [3:0] rx_bits;
		logic [8:0] rx_buf; logic rxc;
	} usd_state_t;
endpackage : usd_pkg
